/* inc/ttc_defines.vh */
// Constants for the transient trigger controller: offsets, fields, timing.
`ifndef TTC_DEFINES_VH
`define TTC_DEFINES_VH

// ************************************************************
// Register offsets (word addresses on the plain port)
// ************************************************************
`define TTC_ADDR_CTRL      4'h0
`define TTC_ADDR_SOURCE    4'h1
`define TTC_ADDR_TRIGGERED_VOLTAGE_LEVEL 4'h2
`define TTC_ADDR_TRIGGERED_CURRENT_LEVEL 4'h3
`define TTC_ADDR_VOLT_IMM  4'h4
`define TTC_ADDR_CURR_IMM  4'h5
`define TTC_ADDR_COMMAND   4'h6
`define TTC_ADDR_OPER_COND 4'h7
`define TTC_ADDR_IRQ_STAT  4'h8
`define TTC_ADDR_IRQ_MASK  4'h9
`define TTC_ADDR_PIN_CFG   4'hA
`define TTC_ADDR_VOLT_OUT  4'hB
`define TTC_ADDR_CURR_OUT  4'hC

// ************************************************************
// Field positions
// ************************************************************
// Control register
`define TTC_CTRL_VSTEP     0
`define TTC_CTRL_CSTEP     1
`define TTC_CTRL_CONT      2
// Command register (write-only pulses)
`define TTC_CMD_INIT       0
`define TTC_CMD_ABORT      1
`define TTC_CMD_IMMED      2
`define TTC_CMD_BUS        3
// Operation condition bits
`define TTC_OPER_WTG       4
`define TTC_OPER_ACTIVE    6
// Interrupt status bits
`define TTC_IRQ_TRIG       0
`define TTC_IRQ_DROP       1
`define TTC_IRQ_IDLE       2

// Source select codes, bits [5:4]; bits [2:0] give pin or channel
`define TTC_SRC_BUS        2'h0
`define TTC_SRC_PIN        2'h1
`define TTC_SRC_TRAN       2'h2
`define TTC_SRC_EXT        2'h3

// ************************************************************
// Reset values
// ************************************************************
`define TTC_RST_CTRL       3'h0
`define TTC_RST_SOURCE     6'h00
`define TTC_RST_LEVEL      16'h0000
`define TTC_RST_PINCFG     8'h00

// ************************************************************
// Timing
// ************************************************************
`define TTC_CLK_MHZ        250
`define TTC_READY_US       2000
`define TTC_READY_CYC      (`TTC_READY_US * `TTC_CLK_MHZ)
`define TTC_SETTLE_CYC     4

`endif

/* logic/ttc_sync_edge.v */
// Two-flop synchroniser bank with rising-edge detection per bit.
module ttc_sync_edge #(
    parameter W = 8
) (
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Asynchronous inputs
    input wire [W-1:0] async_in,
    // Synchronised rising edges, one-cycle pulses
    output wire [W-1:0] rise
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;
    reg [W-1:0] prev_r;

    // First stage feeds only the second stage
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
            prev_r <= {W{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edge taken from the settled stages only
    assign rise = sync_r & ~prev_r;

endmodule

/* logic/ttc_top.v */
// Transient trigger controller for one output channel.
`include "ttc_defines.vh"

module ttc_top #(
    parameter READY_CYC = `TTC_READY_CYC
) (
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // Trigger sources: digital port pins and other channels
    input wire [7:0] port_pin_in,
    input wire [7:0] chan_trig_out_in,
    // Channel setpoints and status
    output reg [15:0] volt_setpoint,
    output reg [15:0] curr_setpoint,
    output wire waiting_for_trigger_flag,
    output wire tran_active_flag,
    output wire irq
);

    // ************************************************************
    // States
    // ************************************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_ARMING = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam ST_ACTION = 2'h3;

    // ************************************************************
    // Registers and wires
    // ************************************************************
    reg [2:0] ctrl_r;
    reg [5:0] trigger_source_select;
    reg [15:0] triggered_voltage_level;
    reg [15:0] triggered_current_level;
    reg [15:0] volt_imm_r;
    reg [15:0] curr_imm_r;
    reg [7:0] pin_cfg_r;
    reg [2:0] irq_stat_r;
    reg [2:0] irq_mask_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [31:0] cnt_r;
    reg [31:0] cnt_nxt;
    reg trig_event;
    wire [7:0] pin_rise;
    wire [7:0] chan_rise;
    wire cmd_wr;
    wire init_cmd;
    wire abort_command;
    wire immed_cmd;
    wire bus_cmd;
    wire [2:0] sel_idx;
    wire accept;
    wire drop;
    wire to_idle;
    wire [2:0] irq_set;
    wire continuous_arm_setting;

    // Returns one bit of an 8-bit vector chosen by a 3-bit index
    function pick;
        input [7:0] vec;
        input [2:0] idx;
        begin
            pick = vec[idx];
        end
    endfunction

    // Register address match, shared by the write and command decode paths
    function hit;
        input [3:0] a;
        input [3:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // ************************************************************
    // Pin and channel trigger synchronisers
    // ************************************************************
    ttc_sync_edge #(
        .W(8)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(port_pin_in),
        .rise(pin_rise)
    );

    // Other channels may run from another clock tree, so sync them too
    ttc_sync_edge #(
        .W(8)
    ) u_chan_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(chan_trig_out_in),
        .rise(chan_rise)
    );

    // ************************************************************
    // Command decode
    // ************************************************************
    assign cmd_wr = reg_wr && hit(reg_addr, `TTC_ADDR_COMMAND);
    assign init_cmd = cmd_wr && reg_wdata[`TTC_CMD_INIT];
    assign abort_command = cmd_wr && reg_wdata[`TTC_CMD_ABORT];
    assign immed_cmd = cmd_wr && reg_wdata[`TTC_CMD_IMMED];
    assign bus_cmd = cmd_wr && reg_wdata[`TTC_CMD_BUS];
    assign continuous_arm_setting = ctrl_r[`TTC_CTRL_CONT];
    assign sel_idx = trigger_source_select[2:0];

    // ************************************************************
    // Trigger source selection
    // ************************************************************
    // A pin only counts while configured as a trigger input
    always @* begin
        trig_event = 1'b0;
        case (trigger_source_select[5:4])
            `TTC_SRC_BUS: begin
                trig_event = bus_cmd;
            end
            `TTC_SRC_PIN: begin
                trig_event = pick(pin_rise & pin_cfg_r, sel_idx);
            end
            `TTC_SRC_TRAN: begin
                trig_event = pick(chan_rise, sel_idx);
            end
            `TTC_SRC_EXT: begin
                trig_event = |(pin_rise & pin_cfg_r);
            end
            default: begin
                trig_event = 1'b0;
            end
        endcase
        if (immed_cmd) begin
            trig_event = 1'b1;
        end
    end

    // Triggers count only in the waiting state; earlier ones are lost
    assign accept = trig_event && (state_r == ST_WAIT) && !abort_command;
    assign drop = trig_event && (state_r == ST_ARMING);

    // ************************************************************
    // Trigger state machine
    // ************************************************************
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                // Idle ignores all triggers
                if (init_cmd || continuous_arm_setting) begin
                    state_nxt = ST_ARMING;
                    cnt_nxt = READY_CYC - 1;
                end
            end
            ST_ARMING: begin
                if (cnt_r == 32'h00000000) begin
                    state_nxt = ST_WAIT;
                end else begin
                    cnt_nxt = cnt_r - 32'h00000001;
                end
            end
            ST_WAIT: begin
                if (accept) begin
                    state_nxt = ST_ACTION;
                    cnt_nxt = `TTC_SETTLE_CYC - 1;
                end
            end
            ST_ACTION: begin
                // Step settles for a few cycles, then back to idle
                if (cnt_r == 32'h00000000) begin
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 32'h00000001;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (abort_command) begin
            state_nxt = ST_IDLE;
            cnt_nxt = 32'h00000000;
        end
    end

    // State register; power-on lands in idle
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cnt_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Flag drops as soon as the state leaves waiting
    assign waiting_for_trigger_flag = (state_r == ST_WAIT);
    assign tran_active_flag = (state_r != ST_IDLE);
    assign to_idle = (state_r != ST_IDLE) && (state_nxt == ST_IDLE);

    // ************************************************************
    // Setpoint outputs
    // ************************************************************
    // Fixed mode keeps the immediate value even on an accepted trigger
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            volt_setpoint <= `TTC_RST_LEVEL;
            curr_setpoint <= `TTC_RST_LEVEL;
        end else begin
            if (accept && ctrl_r[`TTC_CTRL_VSTEP]) begin
                volt_setpoint <= triggered_voltage_level;
            end else begin
                volt_setpoint <= volt_imm_r;
            end
            if (accept && ctrl_r[`TTC_CTRL_CSTEP]) begin
                curr_setpoint <= triggered_current_level;
            end else begin
                curr_setpoint <= curr_imm_r;
            end
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    // Step mode copies the triggered level into the immediate value
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `TTC_RST_CTRL;
            trigger_source_select <= `TTC_RST_SOURCE;
            triggered_voltage_level <= `TTC_RST_LEVEL;
            triggered_current_level <= `TTC_RST_LEVEL;
            volt_imm_r <= `TTC_RST_LEVEL;
            curr_imm_r <= `TTC_RST_LEVEL;
            pin_cfg_r <= `TTC_RST_PINCFG;
            irq_mask_r <= 3'h0;
        end else begin
            if (reg_wr && hit(reg_addr, `TTC_ADDR_CTRL)) begin
                ctrl_r <= reg_wdata[2:0];
            end
            if (reg_wr && hit(reg_addr, `TTC_ADDR_SOURCE)) begin
                trigger_source_select <= reg_wdata[5:0];
            end
            if (reg_wr && hit(reg_addr, `TTC_ADDR_TRIGGERED_VOLTAGE_LEVEL)) begin
                triggered_voltage_level <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `TTC_ADDR_TRIGGERED_CURRENT_LEVEL)) begin
                triggered_current_level <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `TTC_ADDR_PIN_CFG)) begin
                pin_cfg_r <= reg_wdata[7:0];
            end
            if (reg_wr && hit(reg_addr, `TTC_ADDR_IRQ_MASK)) begin
                irq_mask_r <= reg_wdata[2:0];
            end
            // Trigger wins over a software write in the same cycle
            if (accept && ctrl_r[`TTC_CTRL_VSTEP]) begin
                volt_imm_r <= triggered_voltage_level;
            end else if (reg_wr && hit(reg_addr, `TTC_ADDR_VOLT_IMM)) begin
                volt_imm_r <= reg_wdata;
            end
            if (accept && ctrl_r[`TTC_CTRL_CSTEP]) begin
                curr_imm_r <= triggered_current_level;
            end else if (reg_wr && hit(reg_addr, `TTC_ADDR_CURR_IMM)) begin
                curr_imm_r <= reg_wdata;
            end
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign irq_set = {to_idle, drop, accept};

    // Write one to clear; a set in the same cycle wins
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_r <= 3'h0;
        end else if (reg_wr && hit(reg_addr, `TTC_ADDR_IRQ_STAT)) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata[2:0]) | irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ************************************************************
    // Register reads, data one cycle after the strobe
    // ************************************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TTC_ADDR_CTRL: reg_rdata <= {13'h0000, ctrl_r};
                `TTC_ADDR_SOURCE: begin
                    reg_rdata <= {10'h000, trigger_source_select};
                end
                `TTC_ADDR_TRIGGERED_VOLTAGE_LEVEL: reg_rdata <= triggered_voltage_level;
                `TTC_ADDR_TRIGGERED_CURRENT_LEVEL: reg_rdata <= triggered_current_level;
                `TTC_ADDR_VOLT_IMM: reg_rdata <= volt_imm_r;
                `TTC_ADDR_CURR_IMM: reg_rdata <= curr_imm_r;
                `TTC_ADDR_OPER_COND: begin
                    reg_rdata <= {9'h000, tran_active_flag, 1'b0,
                        waiting_for_trigger_flag, 4'h0};
                end
                `TTC_ADDR_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_r};
                `TTC_ADDR_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_r};
                `TTC_ADDR_PIN_CFG: reg_rdata <= {8'h00, pin_cfg_r};
                `TTC_ADDR_VOLT_OUT: reg_rdata <= volt_setpoint;
                `TTC_ADDR_CURR_OUT: reg_rdata <= curr_setpoint;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule

/* dv/ttc_sva.sv */
// Port-level checker for the transient trigger controller.
module ttc_sva #(
    parameter READY_CYC = 8
) (
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    // Outputs watched
    input wire [15:0] volt_setpoint,
    input wire waiting_for_trigger_flag,
    input wire tran_active_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Helper logic
    // ************************************************************
    logic [15:0] busy_cnt_r;
    wire cmd_wr = reg_wr && reg_addr == 4'h6;
    // Cycles spent out of idle; the ready delay is judged against it
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            busy_cnt_r <= 16'h0000;
        else if (!tran_active_flag)
            busy_cnt_r <= 16'h0000;
        else
            busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ************************************************************
    // Assertions
    // ************************************************************
    a_wtg_in_busy: assert property (
        waiting_for_trigger_flag |-> tran_active_flag)
        else $error("waiting flag outside busy state");
    a_ready_delay: assert property (
        waiting_for_trigger_flag |-> busy_cnt_r >= READY_CYC)
        else $error("ready before the delay ran out");
    a_ready_bound: assert property (
        $rose(tran_active_flag) |->
        ##[1:12] (waiting_for_trigger_flag || !tran_active_flag))
        else $error("initiated state never became ready");
    a_init_arms: assert property (
        cmd_wr && reg_wdata[1:0] == 2'h1 && !tran_active_flag
        |=> tran_active_flag)
        else $error("initiate did not leave idle");
    a_abort_idle: assert property (
        cmd_wr && reg_wdata[1] |=> !tran_active_flag)
        else $error("abort did not force idle");
    a_trig_clears: assert property (
        waiting_for_trigger_flag && cmd_wr && reg_wdata[2]
        |=> !waiting_for_trigger_flag)
        else $error("waiting flag held after trigger");
    a_idle_return: assert property (
        $fell(waiting_for_trigger_flag) |-> ##[1:6] !tran_active_flag)
        else $error("no return to idle after action");
    a_idle_deaf: assert property (
        !tran_active_flag |=> !waiting_for_trigger_flag)
        else $error("idle jumped straight to ready");
    a_setp_cause: assert property (
        $changed(volt_setpoint) |-> $past(reg_wr) || $past(reg_wr, 2)
        || $fell(waiting_for_trigger_flag))
        else $error("setpoint moved without a cause");
    c_trig: cover property ($fell(waiting_for_trigger_flag));
    c_abort: cover property (cmd_wr && reg_wdata[1] && tran_active_flag);
    c_arm: cover property ($rose(tran_active_flag));
endmodule

/* dv/ttc_far_end.sv */
// Far-side model: digital port pins and other channels' trigger-out.
module ttc_far_end (
    // Clock
    input wire ref_clk,
    // Trigger lines into the device
    output logic [7:0] port_pin_in,
    output logic [7:0] chan_trig_out_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Lines rest low between pulses
    initial begin
        port_pin_in = 8'h00;
        chan_trig_out_in = 8'h00;
    end
    // One pulse on one line; too short a hold is lost in the synchroniser
    task automatic fire(input bit chan, input logic [2:0] idx,
                        input int hold);
        @(posedge ref_clk);
        if (chan)
            chan_trig_out_in[idx] <= 1'b1;
        else
            port_pin_in[idx] <= 1'b1;
        repeat (hold) @(posedge ref_clk);
        chan_trig_out_in <= 8'h00;
        port_pin_in <= 8'h00;
    endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the transient trigger controller.
`include "ttc_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, resetn, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    wire [15:0] reg_rdata, volt_setpoint, curr_setpoint;
    wire [7:0] port_pin_in, chan_trig_out_in;
    wire waiting_for_trigger_flag, tran_active_flag, irq;
    int error_cnt = 0;
    int num_checks = 0;
    // Short ready delay keeps the run brief
    ttc_top #(.READY_CYC(8)) DUT (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .port_pin_in(port_pin_in),
        .chan_trig_out_in(chan_trig_out_in),
        .volt_setpoint(volt_setpoint),
        .curr_setpoint(curr_setpoint),
        .waiting_for_trigger_flag(waiting_for_trigger_flag),
        .tran_active_flag(tran_active_flag),
        .irq(irq)
    );
    ttc_far_end far_end (
        .ref_clk(ref_clk),
        .port_pin_in(port_pin_in),
        .chan_trig_out_in(chan_trig_out_in)
    );
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // Let the write settle before anyone looks at its effect
        #1;
    endtask
    task automatic cmd(input logic [15:0] d);
        wr(`TTC_ADDR_COMMAND, d);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic wait_wtg(input logic want);
        int n;
        n = 0;
        while (waiting_for_trigger_flag !== want && n < 30) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({15'h0000, waiting_for_trigger_flag}, {15'h0000, want});
    endtask
    task automatic settle;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        rchk(`TTC_ADDR_CTRL, 16'h0000);
        rchk(`TTC_ADDR_OPER_COND, 16'h0000);
        rchk(4'hF, 16'h0000);
        wr(`TTC_ADDR_TRIGGERED_VOLTAGE_LEVEL, 16'h0111);
        wr(`TTC_ADDR_CTRL, 16'h0001);
        cmd(16'h0008);
        cmd(16'h0004);
        settle();
        chk(volt_setpoint, 16'h0000);
    endtask
    task automatic t_early;
        cmd(16'h0001);
        cmd(16'h0008);
        rchk(`TTC_ADDR_OPER_COND, 16'h0040);
        wait_wtg(1'b1);
        rchk(`TTC_ADDR_OPER_COND, 16'h0050);
        chk(volt_setpoint, 16'h0000);
        rchk(`TTC_ADDR_IRQ_STAT, 16'h0002);
        cmd(16'h0002);
        rchk(`TTC_ADDR_OPER_COND, 16'h0000);
    endtask
    // Bus, pin, channel, any-pin, then immediate over an unconfigured pin
    task automatic t_sources;
        logic [15:0] src [5] = '{16'h0000, 16'h0013, 16'h0025,
                                 16'h0030, 16'h0011};
        logic [2:0] hit [5] = '{3'h0, 3'h3, 3'h5, 3'h6, 3'h0};
        logic [2:0] dec [5] = '{3'h0, 3'h6, 3'h4, 3'h1, 3'h1};
        logic [15:0] lvl;
        wr(`TTC_ADDR_PIN_CFG, 16'h0048);
        for (int i = 0; i < 5; i++) begin
            lvl = 16'h1000 + 16'(i);
            wr(`TTC_ADDR_TRIGGERED_VOLTAGE_LEVEL, lvl);
            wr(`TTC_ADDR_SOURCE, src[i]);
            cmd(16'h0001);
            wait_wtg(1'b1);
            if (i > 0) begin
                far_end.fire(i == 2, dec[i], 4);
                settle();
                wait_wtg(1'b1);
            end
            if (i == 0)
                cmd(16'h0008);
            else if (i == 4)
                cmd(16'h0004);
            else
                far_end.fire(i == 2, hit[i], 4);
            settle();
            chk(volt_setpoint, lvl);
            chk({15'h0000, tran_active_flag}, 16'h0000);
        end
    endtask
    // Fixed voltage, stepped current, with the accepted-trigger interrupt
    task automatic t_fixed;
        wr(`TTC_ADDR_CTRL, 16'h0002);
        wr(`TTC_ADDR_SOURCE, 16'h0000);
        wr(`TTC_ADDR_VOLT_IMM, 16'h0222);
        wr(`TTC_ADDR_TRIGGERED_CURRENT_LEVEL, 16'h0333);
        wr(`TTC_ADDR_IRQ_STAT, 16'h0007);
        wr(`TTC_ADDR_IRQ_MASK, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        cmd(16'h0001);
        wait_wtg(1'b1);
        cmd(16'h0008);
        settle();
        chk(volt_setpoint, 16'h0222);
        chk(curr_setpoint, 16'h0333);
        chk({15'h0000, irq}, 16'h0001);
        rchk(`TTC_ADDR_IRQ_STAT, 16'h0005);
        rchk(`TTC_ADDR_CURR_IMM, 16'h0333);
        rchk(`TTC_ADDR_VOLT_OUT, 16'h0222);
        wr(`TTC_ADDR_IRQ_STAT, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
    endtask
    task automatic t_cont;
        wr(`TTC_ADDR_TRIGGERED_VOLTAGE_LEVEL, 16'h0444);
        wr(`TTC_ADDR_CTRL, 16'h0005);
        wait_wtg(1'b1);
        cmd(16'h0008);
        settle();
        chk(volt_setpoint, 16'h0444);
        wait_wtg(1'b1);
        wr(`TTC_ADDR_CTRL, 16'h0000);
        cmd(16'h0002);
        rchk(`TTC_ADDR_OPER_COND, 16'h0000);
    endtask
    // ************************************************************
    // Clock, sequence and watchdog
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_early();
        t_sources();
        t_fixed();
        t_cont();
        finish_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        finish_test();
    end
endmodule
bind ttc_top ttc_sva #(.READY_CYC(READY_CYC)) u_sva (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .volt_setpoint(volt_setpoint),
    .waiting_for_trigger_flag(waiting_for_trigger_flag),
    .tran_active_flag(tran_active_flag)
);
